// File: mfg_pkg.sv
package mfg_pkg;
  // extended register addresses
  localparam logic [15:0] ADDR_CTRL    = 16'h40a0;
  localparam logic [15:0] ADDR_LEN     = 16'h40a1;
  localparam logic [15:0] ADDR_BURST   = 16'h40a2;
  localparam logic [15:0] ADDR_RXGD_HI = 16'h40a3;
  localparam logic [15:0] ADDR_RXGD_LO = 16'h40a4;
  localparam logic [15:0] ADDR_TXGD_HI = 16'h40ad;
  localparam logic [15:0] ADDR_TXGD_LO = 16'h40ae;
  // control field positions
  localparam int B_CHK_EN  = 15;
  localparam int B_GATE_EN = 14;
  localparam int B_BYPASS  = 13;
  localparam int B_GEN_EN  = 12;
  localparam int B_PRE_HI  = 11;
  localparam int B_PRE_LO  = 8;
  localparam int B_GAP_HI  = 7;
  localparam int B_GAP_LO  = 4;
  localparam int B_NOLINK  = 3;
  localparam int B_BADFCS  = 2;
  localparam int B_PL_HI   = 1;
  localparam int B_PL_LO   = 0;
  // reset values and minimum byte field value
  localparam logic [15:0] CTRL_RST  = 16'h68c0;
  localparam logic [15:0] LEN_RST   = 16'h0040;
  localparam logic [15:0] BURST_RST = 16'h0000;
  localparam logic [3:0]  PRE_RST   = 4'h8;
  localparam logic [3:0]  GAP_RST   = 4'hc;
  localparam logic [3:0]  MIN_BYTES = 4'h2;
  // frame constants
  localparam logic [31:0] CRC_POLY   = 32'hedb88320;
  localparam logic [31:0] CRC_RESID  = 32'hdebb20e3;
  localparam logic [31:0] FIX_WORD   = 32'h5aa55aa5;
  localparam logic [15:0] MIN_NIBS   = 16'h0080;
  localparam logic [15:0] MAX_NIBS   = 16'h0bdc;
  localparam logic [15:0] FCS_BYTES  = 16'h0004;
  localparam logic [15:0] LFSR_SEED  = 16'hace1;
  localparam logic [3:0]  NIB_PRE    = 4'h5;
  localparam logic [3:0]  NIB_SFD    = 4'hd;
  typedef enum logic [2:0] {
    G_IDLE = 3'b000,
    G_PRE  = 3'b001,
    G_DATA = 3'b010,
    G_FCS  = 3'b011,
    G_GAP  = 3'b100
  } mfg_gst_t;
endpackage

// File: mfg_selftest.sv
`timescale 1ns/1ps
// Behaviour
// R1: checker enable runs rx checker and tx checker; cleared disables both.
// R2: clocks gated when gate enable, checker off, bypass high, generator off.
// R3: bypass bit 1 forwards mac transmit data, 0 sends generator data.
// R4: generator enable starts frames; they reach transmit only with bypass 0.
// R5: burst count zero means continuous frames until software clears enable.
// R6: nonzero burst stops after that many frames and self-clears enable.
// R7: preamble byte field sets preamble length; values below 2 ignored.
// R8: gap byte field sets inter-frame gap; values below 2 ignored.
// R9: send-without-link allows generation with link down; otherwise link required.
// R10: corrupt fcs bit makes wrong crc, else correct crc.
// R11: payload kind 00 increment, 01 random, 10 fixed word, 11 reserved.
// R12: sixteen-bit frame length register, default 64, sets frame length.
// R13: sixteen-bit burst count register, default 0, frames per burst.
// R14: 32-bit clear-on-read count of good-crc frames 64 to 1518 bytes.
// R15: generator finishes the current frame when software clears enable.
module mfg_selftest
  import mfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_wdata,
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  output logic      [15:0] ext_rdata,
  input  wire logic [3:0]  mac_txd,
  input  wire logic        mac_tx_en,
  input  wire logic        link_up,
  input  wire logic [3:0]  rxd,
  input  wire logic        rx_dv,
  output logic      [3:0]  txd_out,
  output logic             tx_en_out,
  output logic             clk_gate_off
);
  // one nibble of reflected crc-32, lsb first
  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  logic [15:0] ctl_r, ctl_nxt, len_r, len_nxt, burst_r, burst_nxt;
  logic [15:0] sent_r, sent_nxt, cnt_r, cnt_nxt, lfsr_r, lfsr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [3:0]  pre_r, pre_nxt, gap_r, gap_nxt, g_d, txd_r, txd_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic        g_en, txen_r, txen_nxt, gated_r, gated_nxt;
  mfg_gst_t    st_r, st_nxt;
  logic [7:0]  pbyte;
  logic [15:0] plen, last_cnt;
  logic [31:0] ck_cnt_r [2];
  logic [3:0]  ck_d [2];
  logic        ck_dv [2];
  logic        rd_hi [2];
  logic        rd_lo [2];
  logic        gate_cond, may_send;
  assign gate_cond = ctl_r[B_GATE_EN] & ~ctl_r[B_CHK_EN] & ctl_r[B_BYPASS]
                   & ~ctl_r[B_GEN_EN];                                      // [R2]
  assign may_send  = ctl_r[B_GEN_EN] & (link_up | ctl_r[B_NOLINK]) & ~gated_r; // [R9]
  assign plen      = (len_r > FCS_BYTES) ? (len_r - FCS_BYTES) : 16'h0000;  // [R12]
  // register access, generator sequencing and transmit mux
  always_comb begin
    ctl_nxt   = ctl_r;
    len_nxt   = len_r;
    burst_nxt = burst_r;
    pre_nxt   = pre_r;
    gap_nxt   = gap_r;
    sent_nxt  = sent_r;
    cnt_nxt   = cnt_r + 16'h0001;
    lfsr_nxt  = lfsr_r;
    crc_nxt   = crc_r;
    st_nxt    = st_r;
    g_d       = 4'h0;
    g_en      = 1'b0;
    last_cnt  = 16'h0000;
    // payload byte by kind
    case (ctl_r[B_PL_HI:B_PL_LO])                                           // [R11]
      2'b01:   pbyte = lfsr_r[7:0];
      2'b10:   pbyte = cnt_r[1] ? FIX_WORD[23:16] : FIX_WORD[31:24];
      default: pbyte = cnt_r[8:1];
    endcase
    case (st_r)
      G_IDLE: begin
        cnt_nxt = 16'h0000;
        if (may_send) begin                                                 // [R4]
          st_nxt   = G_PRE;
          sent_nxt = 16'h0000;
        end
      end
      G_PRE: begin
        last_cnt = {11'h000, pre_r, 1'b0} - 16'h0001;                        // [R7]
        g_en     = 1'b1;
        g_d      = (cnt_r == last_cnt) ? NIB_SFD : NIB_PRE;
        crc_nxt  = 32'hffffffff;
        if (cnt_r == last_cnt) begin
          cnt_nxt = 16'h0000;
          st_nxt  = (plen == 16'h0000) ? G_FCS : G_DATA;
        end
      end
      G_DATA: begin
        last_cnt = {plen[14:0], 1'b0} - 16'h0001;
        g_en     = 1'b1;
        g_d      = cnt_r[0] ? pbyte[7:4] : pbyte[3:0];
        crc_nxt  = crc_nib(crc_r, g_d);
        if (cnt_r[0]) lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        if (cnt_r == last_cnt) begin
          cnt_nxt = 16'h0000;
          st_nxt  = G_FCS;
        end
      end
      G_FCS: begin
        g_en    = 1'b1;
        g_d     = ~crc_r[3:0] ^ {3'b000, ctl_r[B_BADFCS] & (cnt_r == 16'h0000)}; // [R10]
        crc_nxt = crc_r >> 4;
        if (cnt_r == 16'h0007) begin
          cnt_nxt  = 16'h0000;
          sent_nxt = sent_r + 16'h0001;
          st_nxt   = G_GAP;
        end
      end
      G_GAP: begin
        last_cnt = {11'h000, gap_r, 1'b0} - 16'h0001;                        // [R8]
        if (cnt_r == last_cnt) begin
          cnt_nxt = 16'h0000;
          if (burst_r != 16'h0000 && sent_r >= burst_r) begin
            ctl_nxt[B_GEN_EN] = 1'b0;                                       // [R6]
            st_nxt            = G_IDLE;
          end else begin
            st_nxt = may_send ? G_PRE : G_IDLE;                             // [R5] [R15]
          end
        end
      end
      default: st_nxt = G_IDLE;
    endcase
    if (gated_r) cnt_nxt = cnt_r;
    // software write after hardware clear, so a software set wins
    if (ext_wr) begin
      if (ext_addr == ADDR_CTRL) begin
        ctl_nxt = ext_wdata;
        if (ext_wdata[B_PRE_HI:B_PRE_LO] >= MIN_BYTES) begin
          pre_nxt = ext_wdata[B_PRE_HI:B_PRE_LO];                           // [R7]
        end
        if (ext_wdata[B_GAP_HI:B_GAP_LO] >= MIN_BYTES) begin
          gap_nxt = ext_wdata[B_GAP_HI:B_GAP_LO];                           // [R8]
        end
      end else if (ext_addr == ADDR_LEN) begin
        len_nxt = ext_wdata;                                                // [R12]
      end else if (ext_addr == ADDR_BURST) begin
        burst_nxt = ext_wdata;                                              // [R13]
      end
    end
    // read data
    if (ext_addr == ADDR_CTRL) rdata_nxt = ctl_r;
    else if (ext_addr == ADDR_LEN) rdata_nxt = len_r;
    else if (ext_addr == ADDR_BURST) rdata_nxt = burst_r;
    else if (ext_addr == ADDR_RXGD_HI) rdata_nxt = ck_cnt_r[0][31:16];
    else if (ext_addr == ADDR_RXGD_LO) rdata_nxt = ck_cnt_r[0][15:0];
    else if (ext_addr == ADDR_TXGD_HI) rdata_nxt = ck_cnt_r[1][31:16];
    else if (ext_addr == ADDR_TXGD_LO) rdata_nxt = ck_cnt_r[1][15:0];
    else rdata_nxt = 16'h0000;
    if (!ext_rd) rdata_nxt = rdata_r;
    // transmit source select
    txd_nxt   = ctl_r[B_BYPASS] ? mac_txd : g_d;                            // [R3]
    txen_nxt  = ctl_r[B_BYPASS] ? mac_tx_en : g_en;                         // [R4]
    gated_nxt = gate_cond;                                                  // [R2]
  end
  // generator and register state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctl_r   <= CTRL_RST;
      len_r   <= LEN_RST;
      burst_r <= BURST_RST;
      pre_r   <= PRE_RST;
      gap_r   <= GAP_RST;
      sent_r  <= 16'h0000;
      cnt_r   <= 16'h0000;
      lfsr_r  <= LFSR_SEED;
      crc_r   <= 32'hffffffff;
      st_r    <= G_IDLE;
      rdata_r <= 16'h0000;
      txd_r   <= 4'h0;
      txen_r  <= 1'b0;
      gated_r <= 1'b0;
    end else begin
      ctl_r   <= ctl_nxt;
      len_r   <= len_nxt;
      burst_r <= burst_nxt;
      pre_r   <= pre_nxt;
      gap_r   <= gap_nxt;
      sent_r  <= sent_nxt;
      cnt_r   <= cnt_nxt;
      lfsr_r  <= lfsr_nxt;
      crc_r   <= crc_nxt;
      st_r    <= st_nxt;
      rdata_r <= rdata_nxt;
      txd_r   <= txd_nxt;
      txen_r  <= txen_nxt;
      gated_r <= gated_nxt;
    end
  end
  assign ext_rdata    = rdata_r;
  assign txd_out      = txd_r;
  assign tx_en_out    = txen_r;
  assign clk_gate_off = gated_r;
  // checker inputs: channel 0 receive, channel 1 internal transmit
  assign ck_d[0]  = rxd;
  assign ck_dv[0] = rx_dv;
  assign ck_d[1]  = txd_r;
  assign ck_dv[1] = txen_r;
  assign rd_hi[0] = ext_rd & (ext_addr == ADDR_RXGD_HI);
  assign rd_lo[0] = ext_rd & (ext_addr == ADDR_RXGD_LO);
  assign rd_hi[1] = ext_rd & (ext_addr == ADDR_TXGD_HI);
  assign rd_lo[1] = ext_rd & (ext_addr == ADDR_TXGD_LO);
  // frame checkers
  for (genvar g = 0; g < 2; g++) begin : gen_chk
    logic        in_r, in_nxt, dvd_r, dvd_nxt;
    logic [15:0] n_r, n_nxt;
    logic [31:0] c_r, c_nxt, k_nxt;
    always_comb begin
      in_nxt  = in_r;
      n_nxt   = n_r;
      c_nxt   = c_r;
      k_nxt   = ck_cnt_r[g];
      dvd_nxt = ck_dv[g];
      if (rd_hi[g]) k_nxt[31:16] = 16'h0000;                                // [R14]
      if (rd_lo[g]) k_nxt[15:0] = 16'h0000;
      if (!ctl_r[B_CHK_EN] || gated_r) begin                                // [R1]
        in_nxt = 1'b0;
      end else if (ck_dv[g]) begin
        if (!in_r && ck_d[g] == NIB_SFD) begin
          in_nxt = 1'b1;
          n_nxt  = 16'h0000;
          c_nxt  = 32'hffffffff;
        end else if (in_r) begin
          n_nxt = n_r + 16'h0001;
          c_nxt = crc_nib(c_r, ck_d[g]);
        end
      end else begin
        in_nxt = 1'b0;
        if (in_r && dvd_r && c_r == CRC_RESID && n_r >= MIN_NIBS && n_r <= MAX_NIBS) begin
          k_nxt = k_nxt + 32'h00000001;                                     // [R14]
        end
      end
    end
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        in_r        <= 1'b0;
        dvd_r       <= 1'b0;
        n_r         <= 16'h0000;
        c_r         <= 32'hffffffff;
        ck_cnt_r[g] <= 32'h00000000;
      end else begin
        in_r        <= in_nxt;
        dvd_r       <= dvd_nxt;
        n_r         <= n_nxt;
        c_r         <= c_nxt;
        ck_cnt_r[g] <= k_nxt;
      end
    end
  end
  // checks
  a_gate_follow: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
    gate_cond |=> clk_gate_off) else $error("gate not applied");
  a_bypass_pass: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
    ctl_r[B_BYPASS] |=> (tx_en_out == $past(mac_tx_en) && txd_out == $past(mac_txd)))
    else $error("bypass data not forwarded");
  a_start_gen: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
    (st_r == G_IDLE && may_send) |=> st_r == G_PRE) else $error("generator did not start");
  a_cont_keep: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
    (burst_r == 16'h0000 && ctl_r[B_GEN_EN] && !ext_wr) |=> ctl_r[B_GEN_EN])
    else $error("continuous mode self-cleared");
  a_burst_stop: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
    (st_r == G_GAP && cnt_r == last_cnt && burst_r != 16'h0000 && sent_r >= burst_r
     && !ext_wr) |=> (!ctl_r[B_GEN_EN] && st_r == G_IDLE)) else $error("burst did not stop");
  a_len_floor: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
    (pre_r >= MIN_BYTES && gap_r >= MIN_BYTES)) else $error("length below two bytes");
  a_no_link: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
    (st_r == G_IDLE && !link_up && !ctl_r[B_NOLINK]) |=> st_r == G_IDLE)
    else $error("sent without link");
  a_fcs_span: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
    $rose(st_r == G_FCS) |-> (st_r == G_FCS)[*8] ##1 st_r == G_GAP)
    else $error("fcs not eight nibbles");
  a_chk_off: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
    (!ctl_r[B_CHK_EN] && !ext_rd) |=> $stable(ck_cnt_r[0])) else $error("checker counted");
  a_finish_frame: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
    (st_r == G_DATA && !ctl_r[B_GEN_EN]) |=> (st_r == G_DATA || st_r == G_FCS))
    else $error("frame truncated");
  c_burst_done: cover property (@(posedge sys_clk) $fell(ctl_r[B_GEN_EN]) && !ext_wr);
  c_rx_good: cover property (@(posedge sys_clk) ck_cnt_r[0] != $past(ck_cnt_r[0]) && !ext_rd);
  c_back_to_back: cover property (@(posedge sys_clk) st_r == G_GAP ##1 st_r == G_PRE);
endmodule

// File: mfg_mac_model.sv
`timescale 1ns/1ps
// mac transmit source: sends a counted run of nibbles after each go pulse
module mfg_mac_model (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [7:0] nibs,
  output logic      [3:0] mac_txd,
  output logic            mac_tx_en
);
  logic [7:0] left_r = 8'h00;
  initial mac_txd = 4'h0;
  initial mac_tx_en = 1'b0;
  // data changes on the edge by non-blocking update; idle data toggles so stale values never match
  always @(posedge sys_clk) begin
    if (go) begin
      left_r <= nibs;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
    mac_tx_en <= (left_r != 8'h00);
    mac_txd   <= (left_r != 8'h00) ? left_r[3:0] : ~mac_txd;
  end
endmodule

// File: mfg_selftest_tb_top.sv
`timescale 1ns/1ps
module mfg_selftest_tb_top;
  import mfg_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [15:0] ext_addr  = 16'h0000;
  logic [15:0] ext_wdata = 16'h0000;
  logic        ext_wr    = 1'b0;
  logic        ext_rd    = 1'b0;
  logic        link_up   = 1'b1;
  logic        loop      = 1'b0;
  logic        go        = 1'b0;
  logic [15:0] ext_rdata;
  logic [3:0]  mac_txd;
  logic        mac_tx_en;
  logic [3:0]  txd_out;
  logic        tx_en_out;
  logic        clk_gate_off;
  logic [3:0]  q[$];
  int          fails     = 0;
  int          compares  = 0;
  always #5 sys_clk = ~sys_clk;
  mfg_selftest mfg_selftest_inst (
    .sys_clk(sys_clk), .reset(reset), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_rdata(ext_rdata), .mac_txd(mac_txd),
    .mac_tx_en(mac_tx_en), .link_up(link_up), .rxd(loop ? txd_out : 4'h0),
    .rx_dv(loop & tx_en_out), .txd_out(txd_out), .tx_en_out(tx_en_out),
    .clk_gate_off(clk_gate_off));
  mfg_mac_model mfg_mac_model_inst (
    .sys_clk(sys_clk), .go(go), .nibs(8'h0c), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // register write: one-cycle strobe, launched just after an edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    step();
    ext_addr = a;
    ext_wdata = d;
    ext_wr = 1'b1;
    step();
    ext_wr = 1'b0;
  endtask
  // register read: data is registered at the strobe edge
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    step();
    ext_addr = a;
    ext_rd = 1'b1;
    step();
    ext_rd = 1'b0;
    check(ext_rdata, exp);
  endtask
  // capture one generated frame and judge preamble, payload and fcs
  task automatic frame(input int p, input int len, input int kind, input bit bad);
    int n;
    logic [31:0] crc;
    logic [7:0] b;
    q.delete();
    for (n = 0; n < 300 && tx_en_out !== 1'b1; n++) step();
    while (tx_en_out === 1'b1 && q.size() < 400) begin
      q.push_back(txd_out);
      step();
    end
    check(q.size(), 2 * p + 2 * (len - 4) + 8);
    for (n = 0; n < 2 * p - 1; n++) check(q[n], NIB_PRE);
    check(q[2 * p - 1], NIB_SFD);
    crc = 32'hffffffff;
    for (n = 2 * p; n < q.size() - 8; n++) begin
      b = (kind == 2) ? (((n - 2 * p) % 4 < 2) ? 8'h5a : 8'ha5) : 8'((n - 2 * p) / 2);
      if (kind != 1) check(q[n], ((n - 2 * p) % 2) ? b[7:4] : b[3:0]);
      crc = crc ^ {28'h0, q[n]};
      repeat (4) crc = crc[0] ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
    end
    crc = ~crc ^ {31'h0, bad};
    for (n = 0; n < 8; n++) check(q[q.size() - 8 + n], crc[4 * n +: 4]);
  endtask
  task automatic t_reset();
    check(clk_gate_off, 1'b1);
    rdchk(ADDR_CTRL, CTRL_RST);
    rdchk(ADDR_LEN, LEN_RST);
    rdchk(ADDR_BURST, BURST_RST);
    rdchk(16'h40a5, 16'h0000);
    wr(ADDR_LEN, 16'h1234);
    rdchk(ADDR_LEN, 16'h1234);
    $display("test reset done");
  endtask
  // bypass: mac data shows on the transceiver side one cycle later
  task automatic t_bypass();
    logic [4:0] prev;
    step();
    go = 1'b1;
    step();
    go = 1'b0;
    prev = {mac_tx_en, mac_txd};
    repeat (16) begin
      step();
      check({tx_en_out, txd_out}, prev);
      prev = {mac_tx_en, mac_txd};
    end
    $display("test bypass done");
  endtask
  // one-frame bursts over every payload kind, alternating fcs corruption
  task automatic t_burst();
    wr(ADDR_BURST, 16'h0001);
    wr(ADDR_LEN, 16'h0008);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 16'h1228 | 16'((k % 2) << 2) | 16'(k));
      step();
      check(clk_gate_off, 1'b0);
      frame(2, 8, k, k % 2);
      repeat (12) step();
      check(tx_en_out, 1'b0);
      rdchk(ADDR_CTRL, 16'h0228 | 16'((k % 2) << 2) | 16'(k));
    end
    $display("test burst done");
  endtask
  // continuous run with refused short fields, then clear enable during the preamble and let the frame finish
  task automatic t_cont();
    int n;
    logic seen;
    wr(ADDR_BURST, 16'h0000);
    wr(ADDR_CTRL, 16'h1118);
    frame(2, 8, 0, 0);
    for (n = 0; n < 100 && tx_en_out !== 1'b1; n++) step();
    check(n, 4);
    wr(ADDR_CTRL, 16'h0118);
    for (n = 0; n < 100 && tx_en_out === 1'b1; n++) step();
    check(n, 18);
    seen = 1'b0;
    repeat (40) begin
      step();
      seen = seen | tx_en_out;
    end
    check(seen, 1'b0);
    $display("test continuous done");
  endtask
  task automatic t_link();
    logic seen;
    wr(ADDR_BURST, 16'h0001);
    link_up = 1'b0;
    wr(ADDR_CTRL, 16'h1220);
    seen = 1'b0;
    repeat (40) begin
      step();
      seen = seen | tx_en_out;
    end
    check(seen, 1'b0);
    link_up = 1'b1;
    frame(2, 8, 0, 0);
    $display("test link done");
  endtask
  // frames looped into the receive side; counters cleared by reading
  task automatic t_check();
    loop = 1'b1;
    wr(ADDR_LEN, 16'h0040);
    wr(ADDR_CTRL, 16'h9228);
    frame(2, 64, 0, 0);
    repeat (8) step();
    rdchk(ADDR_RXGD_LO, 16'h0001);
    rdchk(ADDR_RXGD_HI, 16'h0000);
    rdchk(ADDR_TXGD_LO, 16'h0001);
    rdchk(ADDR_RXGD_LO, 16'h0000);
    wr(ADDR_CTRL, 16'h1228);
    frame(2, 64, 0, 0);
    repeat (8) step();
    wr(ADDR_CTRL, 16'h922c);
    frame(2, 64, 0, 1);
    repeat (8) step();
    rdchk(ADDR_RXGD_LO, 16'h0000);
    loop = 1'b0;
    $display("test checker done");
  endtask
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    step();
    t_reset();
    t_bypass();
    t_burst();
    t_cont();
    t_link();
    t_check();
    stop_test();
  end
endmodule
